// ===== logic/pdepf_pkg.sv
// Package of register map, field layout and encodings for the port D/E pin function block.
package pdepf_pkg;

  // ****************************************************************
  // Bus geometry
  // ****************************************************************
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W  = 16;
  localparam int unsigned PD_W   = 8;
  localparam int unsigned PE_W   = 16;

  // ****************************************************************
  // Register indices as printed, and the byte address of each word
  // ****************************************************************
  localparam logic [31:0] PORTD_FS1_IDX  = 32'hffff83ad;
  localparam logic [31:0] PE_DATA_IDX    = 32'hffff83b0;
  localparam logic [31:0] PE_DIR_IDX     = 32'hffff83b4;
  localparam logic [31:0] PE_FS1_IDX     = 32'hffff83b8;
  localparam logic [31:0] PE_FS2_IDX     = 32'hffff83ba;

  localparam logic [ADDR_W-1:0] PORTD_FS1_ADDR = {PORTD_FS1_IDX[9:0], 2'h0};
  localparam logic [ADDR_W-1:0] PE_DATA_ADDR   = {PE_DATA_IDX[9:0], 2'h0};
  localparam logic [ADDR_W-1:0] PE_DIR_ADDR    = {PE_DIR_IDX[9:0], 2'h0};
  localparam logic [ADDR_W-1:0] PE_FS1_ADDR    = {PE_FS1_IDX[9:0], 2'h0};
  localparam logic [ADDR_W-1:0] PE_FS2_ADDR    = {PE_FS2_IDX[9:0], 2'h0};
  localparam logic [ADDR_W-1:0] PORTD_FS2_ADDR = 12'hf00;

  // ****************************************************************
  // Reset values and field layout
  // ****************************************************************
  localparam logic [REG_W-1:0] REG_RESET = 16'h0000;
  localparam logic [1:0]  MODE_PORT      = 2'h0;
  localparam logic [1:0]  MODE_TIMER     = 2'h1;
  localparam int unsigned PE_LO_LAST     = 7;
  localparam int unsigned PE_HI_FIRST    = 13;
  localparam int unsigned PE_HI_FLD_BASE = 10;
  localparam int unsigned TIMER_PIN      = 0;

  // ****************************************************************
  // AXI responses
  // ****************************************************************
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ===== logic/pdepf_top.sv
// Port D/E pin function controller with AXI4-Lite register slave.
`timescale 1ns/1ps

module pdepf_top (
  input  wire logic        CORE_CLK_I,
  input  wire logic        SYS_RST_I,
  input  wire logic        CORE_CE_I,
  input  wire logic [11:0] S_AXI_AWADDR_I,
  input  wire logic        S_AXI_AWVALID_I,
  output logic             S_AXI_AWREADY_O,
  input  wire logic [31:0] S_AXI_WDATA_I,
  input  wire logic [3:0]  S_AXI_WSTRB_I,
  input  wire logic        S_AXI_WVALID_I,
  output logic             S_AXI_WREADY_O,
  output logic [1:0]       S_AXI_BRESP_O,
  output logic             S_AXI_BVALID_O,
  input  wire logic        S_AXI_BREADY_I,
  input  wire logic [11:0] S_AXI_ARADDR_I,
  input  wire logic        S_AXI_ARVALID_I,
  output logic             S_AXI_ARREADY_O,
  output logic [31:0]      S_AXI_RDATA_O,
  output logic [1:0]       S_AXI_RRESP_O,
  output logic             S_AXI_RVALID_O,
  input  wire logic        S_AXI_RREADY_I,
  input  wire logic [7:0]  PD_IN_I,
  output logic [7:0]       PD_OUT_O,
  output logic [7:0]       PD_OE_O,
  input  wire logic [7:0]  DBUS_OUT_I,
  input  wire logic        DBUS_OE_I,
  output logic [7:0]       DBUS_IN_O,
  input  wire logic [15:0] PE_IN_I,
  output logic [15:0]      PE_OUT_O,
  output logic [15:0]      PE_OE_O,
  input  wire logic        TMR_CMP_A_I,
  input  wire logic        TMR_OE_I
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [15:0] portd_low_function_select_1;
  logic [15:0] portd_low_function_select_2;
  logic [15:0] porte_low_data;
  logic [15:0] porte_low_direction;
  logic [15:0] porte_low_function_select_1;
  logic [15:0] porte_low_function_select_2;

  // ****************************************************************
  // AXI4-Lite decode
  // ****************************************************************
  // Address and data are taken together; a single pulse of both readies marks the handshake.
  wire         aw_hs      = S_AXI_AWVALID_I & S_AXI_AWREADY_O;
  wire         ar_hs      = S_AXI_ARVALID_I & S_AXI_ARREADY_O;
  wire         wr_start   = S_AXI_AWVALID_I & S_AXI_WVALID_I & ~S_AXI_AWREADY_O & ~S_AXI_BVALID_O;
  wire         rd_start   = S_AXI_ARVALID_I & ~S_AXI_ARREADY_O & ~S_AXI_RVALID_O;
  wire         wr_pd1     = aw_hs & (S_AXI_AWADDR_I == pdepf_pkg::PORTD_FS1_ADDR);
  wire         wr_pd2     = aw_hs & (S_AXI_AWADDR_I == pdepf_pkg::PORTD_FS2_ADDR);
  wire         wr_dat     = aw_hs & (S_AXI_AWADDR_I == pdepf_pkg::PE_DATA_ADDR);
  wire         wr_dir     = aw_hs & (S_AXI_AWADDR_I == pdepf_pkg::PE_DIR_ADDR);
  wire         wr_pe1     = aw_hs & (S_AXI_AWADDR_I == pdepf_pkg::PE_FS1_ADDR);
  wire         wr_pe2     = aw_hs & (S_AXI_AWADDR_I == pdepf_pkg::PE_FS2_ADDR);
  wire         wr_hit     = wr_pd1 | wr_pd2 | wr_dat | wr_dir | wr_pe1 | wr_pe2;
  wire         ar_is_data = S_AXI_ARADDR_I == pdepf_pkg::PE_DATA_ADDR;
  wire [15:0]  wmask      = {{8{S_AXI_WSTRB_I[1]}}, {8{S_AXI_WSTRB_I[0]}}};

  // Merge the written lanes into a register value; unstrobed bytes keep their contents.
  function automatic logic [15:0] merge(input logic [15:0] old_v, input logic [15:0] new_v,
                                        input logic [15:0] m);
    merge = (old_v & ~m) | (new_v & m);
  endfunction

  // Data register read shows the latch on output pins and the live level on input pins.
  wire [15:0]  pe_read    = (porte_low_data & porte_low_direction) |
                            (PE_IN_I & ~porte_low_direction);

  logic [15:0] rd_word;
  logic        rd_hit;
  always_comb begin
    rd_hit  = 1'b1;
    rd_word = pdepf_pkg::REG_RESET;
    unique case (S_AXI_ARADDR_I)
      pdepf_pkg::PORTD_FS1_ADDR: rd_word = portd_low_function_select_1;
      pdepf_pkg::PORTD_FS2_ADDR: rd_word = portd_low_function_select_2;
      pdepf_pkg::PE_DATA_ADDR:   rd_word = pe_read;
      pdepf_pkg::PE_DIR_ADDR:    rd_word = porte_low_direction;
      pdepf_pkg::PE_FS1_ADDR:    rd_word = porte_low_function_select_1;
      pdepf_pkg::PE_FS2_ADDR:    rd_word = porte_low_function_select_2;
      default:                   rd_hit  = 1'b0;
    endcase
  end

  // ****************************************************************
  // Bus handshake state
  // ****************************************************************
  // Write answers one cycle after the ready pulse; unmapped addresses get SLVERR.
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      S_AXI_AWREADY_O <= 1'b0;
      S_AXI_WREADY_O  <= 1'b0;
      S_AXI_BVALID_O  <= 1'b0;
      S_AXI_BRESP_O   <= pdepf_pkg::RESP_OKAY;
    end else if (CORE_CE_I) begin
      S_AXI_AWREADY_O <= wr_start;
      S_AXI_WREADY_O  <= wr_start;
      if (aw_hs) begin
        S_AXI_BVALID_O <= 1'b1;
        S_AXI_BRESP_O  <= wr_hit ? pdepf_pkg::RESP_OKAY : pdepf_pkg::RESP_SLVERR;
      end else if (S_AXI_BREADY_I) begin
        S_AXI_BVALID_O <= 1'b0;
      end
    end
  end

  // Read data is captured at the address handshake and held until taken.
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      S_AXI_ARREADY_O <= 1'b0;
      S_AXI_RVALID_O  <= 1'b0;
      S_AXI_RDATA_O   <= 32'h0000_0000;
      S_AXI_RRESP_O   <= pdepf_pkg::RESP_OKAY;
    end else if (CORE_CE_I) begin
      S_AXI_ARREADY_O <= rd_start;
      if (ar_hs) begin
        S_AXI_RVALID_O <= 1'b1;
        S_AXI_RDATA_O  <= {16'h0000, rd_word};
        S_AXI_RRESP_O  <= rd_hit ? pdepf_pkg::RESP_OKAY : pdepf_pkg::RESP_SLVERR;
      end else if (S_AXI_RREADY_I) begin
        S_AXI_RVALID_O <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Register file
  // ****************************************************************
  // All six registers are written with byte-lane strobes; five read back as written, the port E data word reads input pins live.
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      portd_low_function_select_1 <= pdepf_pkg::REG_RESET;
      portd_low_function_select_2 <= pdepf_pkg::REG_RESET;
      porte_low_data              <= pdepf_pkg::REG_RESET;
      porte_low_direction         <= pdepf_pkg::REG_RESET;
      porte_low_function_select_1 <= pdepf_pkg::REG_RESET;
      porte_low_function_select_2 <= pdepf_pkg::REG_RESET;
    end else if (CORE_CE_I) begin
      if (wr_pd1) portd_low_function_select_1 <= merge(portd_low_function_select_1,
                                                       S_AXI_WDATA_I[15:0], wmask);
      if (wr_pd2) portd_low_function_select_2 <= merge(portd_low_function_select_2,
                                                       S_AXI_WDATA_I[15:0], wmask);
      if (wr_dat) porte_low_data <= merge(porte_low_data, S_AXI_WDATA_I[15:0], wmask);
      if (wr_dir) porte_low_direction <= merge(porte_low_direction,
                                               S_AXI_WDATA_I[15:0], wmask);
      if (wr_pe1) porte_low_function_select_1 <= merge(porte_low_function_select_1,
                                                       S_AXI_WDATA_I[15:0], wmask);
      if (wr_pe2) porte_low_function_select_2 <= merge(porte_low_function_select_2,
                                                       S_AXI_WDATA_I[15:0], wmask);
    end
  end

  // ****************************************************************
  // Port D pin routing
  // ****************************************************************
  // Bus-owned pins follow the bus controller; port-owned pins are released since
  // this block holds no port D data or direction latch.
  wire [7:0] pd_bus_sel   = portd_low_function_select_1[7:0];
  wire [7:0] next_pd_out  = DBUS_OUT_I & pd_bus_sel;
  wire [7:0] next_pd_oe   = {8{DBUS_OE_I}} & pd_bus_sel;
  wire [7:0] next_dbus_in = PD_IN_I & pd_bus_sel;

  // ****************************************************************
  // Port E pin routing
  // ****************************************************************
  // Each pin decodes only its own field, so a stray code never disturbs a neighbour.
  logic [15:0] next_pe_out;
  logic [15:0] next_pe_oe;
  logic [15:0] pe_port_mode;
  logic [15:0] pe_timer_mode;
  genvar k;
  generate
    for (k = 0; k < pdepf_pkg::PE_W; k++) begin : g_pe
      logic [1:0] fld;
      if (k <= pdepf_pkg::PE_LO_LAST) begin : g_lo
        assign fld = porte_low_function_select_2[2*k+1:2*k];
      end else if (k >= pdepf_pkg::PE_HI_FIRST) begin : g_hi
        assign fld = porte_low_function_select_1[pdepf_pkg::PE_HI_FLD_BASE +
                     2*(k-pdepf_pkg::PE_HI_FIRST) +: 2];
      end else begin : g_mid
        assign fld = pdepf_pkg::MODE_PORT;
      end
      assign pe_port_mode[k]  = fld == pdepf_pkg::MODE_PORT;
      assign pe_timer_mode[k] = (k == pdepf_pkg::TIMER_PIN) &&
                                (fld == pdepf_pkg::MODE_TIMER);
      assign next_pe_out[k] = pe_timer_mode[k] ? TMR_CMP_A_I :
                              (pe_port_mode[k] & porte_low_data[k]);
      assign next_pe_oe[k]  = pe_timer_mode[k] ? TMR_OE_I :
                              (pe_port_mode[k] & porte_low_direction[k]);
    end
  endgenerate

  // Pins are registered so every output leaves a flip-flop; costs one cycle of latency.
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      PD_OUT_O  <= 8'h00;
      PD_OE_O   <= 8'h00;
      DBUS_IN_O <= 8'h00;
      PE_OUT_O  <= 16'h0000;
      PE_OE_O   <= 16'h0000;
    end else if (CORE_CE_I) begin
      PD_OUT_O  <= next_pd_out;
      PD_OE_O   <= next_pd_oe;
      DBUS_IN_O <= next_dbus_in;
      PE_OUT_O  <= next_pe_out;
      PE_OE_O   <= next_pe_oe;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence s_data_read;
    ar_hs && ar_is_data && CORE_CE_I;
  endsequence

  property p_pd_bus_route;
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    CORE_CE_I |=> ((PD_OUT_O & $past(pd_bus_sel)) == ($past(DBUS_OUT_I) & $past(pd_bus_sel)));
  endproperty
  a_pd_bus_route: assert property (p_pd_bus_route) else $error("port D bus data misrouted");

  property p_pd_port_release;
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    CORE_CE_I |=> ((PD_OE_O & ~$past(pd_bus_sel)) == 8'h00);
  endproperty
  a_pd_port_release: assert property (p_pd_port_release) else $error("port D pin driven");

  property p_dir_written;
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (wr_dir && CORE_CE_I && S_AXI_WSTRB_I[1:0] == 2'h3)
      |=> porte_low_direction == $past(S_AXI_WDATA_I[15:0]) ##1 1'b1;
  endproperty
  a_dir_written: assert property (p_dir_written) else $error("direction write lost");

  property p_pd_written;
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (wr_pd1 && CORE_CE_I && S_AXI_WSTRB_I[1:0] == 2'h3)
      |=> portd_low_function_select_1 == $past(S_AXI_WDATA_I[15:0]);
  endproperty
  a_pd_written: assert property (p_pd_written) else $error("port D select write lost");

  property p_pe_out;
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    CORE_CE_I |=> ((PE_OUT_O & $past(pe_port_mode & porte_low_direction)) ==
                   $past(porte_low_data & pe_port_mode & porte_low_direction)) &&
                  ((PE_OE_O & $past(pe_port_mode)) == $past(porte_low_direction & pe_port_mode));
  endproperty
  a_pe_out: assert property (p_pe_out) else $error("port E output mismatch");

  property p_pe_read;
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    s_data_read |=> S_AXI_RVALID_O && S_AXI_RDATA_O[15:0] ==
      (($past(porte_low_data) & $past(porte_low_direction)) |
       ($past(PE_IN_I) & ~$past(porte_low_direction)));
  endproperty
  a_pe_read: assert property (p_pe_read) else $error("port E read wrong");

  property p_timer_pin;
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (CORE_CE_I && porte_low_function_select_2[1:0] == pdepf_pkg::MODE_TIMER)
      |=> PE_OUT_O[0] == $past(TMR_CMP_A_I) && PE_OE_O[0] == $past(TMR_OE_I);
  endproperty
  a_timer_pin: assert property (p_timer_pin) else $error("pin 0 not on timer");

  property p_lo_other_mode;
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (CORE_CE_I && porte_low_function_select_2[3:2] != pdepf_pkg::MODE_PORT) |=> !PE_OE_O[1];
  endproperty
  a_lo_other_mode: assert property (p_lo_other_mode) else $error("pin 1 driven");

  property p_hi_other_mode;
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (CORE_CE_I && porte_low_function_select_1[13:12] != pdepf_pkg::MODE_PORT)
      |=> !PE_OE_O[14] && !PE_OUT_O[14];
  endproperty
  a_hi_other_mode: assert property (p_hi_other_mode) else $error("pin 14 driven");

  property p_wr_resp;
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (aw_hs && CORE_CE_I) |=> S_AXI_BVALID_O && !S_AXI_AWREADY_O;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write response missing");

  property p_wr_take;
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (wr_start && CORE_CE_I) |=> S_AXI_AWREADY_O && S_AXI_WREADY_O;
  endproperty
  a_wr_take: assert property (p_wr_take) else $error("write not accepted");

  // The response must drop at an edge that sees the master's ready high.
  property p_bvalid_drop;
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (S_AXI_BVALID_O && S_AXI_BREADY_I && !aw_hs && CORE_CE_I) |=> !S_AXI_BVALID_O;
  endproperty
  a_bvalid_drop: assert property (p_bvalid_drop) else $error("write response stuck");

  property p_rd_resp;
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (ar_hs && CORE_CE_I) |=> S_AXI_RVALID_O && !S_AXI_ARREADY_O;
  endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("read response missing");

  property p_rvalid_drop;
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (S_AXI_RVALID_O && S_AXI_RREADY_I && !ar_hs && CORE_CE_I) |=> !S_AXI_RVALID_O;
  endproperty
  a_rvalid_drop: assert property (p_rvalid_drop) else $error("read response stuck");

  property p_rd_unmapped;
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (ar_hs && CORE_CE_I && !rd_hit) |=> (S_AXI_RRESP_O == pdepf_pkg::RESP_SLVERR) &&
                                        (S_AXI_RDATA_O == 32'h0000_0000);
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read answered");

  property p_dbus_in;
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    CORE_CE_I |=> DBUS_IN_O == ($past(PD_IN_I) & $past(pd_bus_sel));
  endproperty
  a_dbus_in: assert property (p_dbus_in) else $error("port D bus input misrouted");

  // Pins without a mode field must always behave as plain port pins.
  property p_mid_port;
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    CORE_CE_I |=> (PE_OE_O[12:8] == $past(porte_low_direction[12:8])) &&
                  (PE_OUT_O[12:8] == $past(porte_low_data[12:8]));
  endproperty
  a_mid_port: assert property (p_mid_port) else $error("port E middle pins misrouted");

  // A low enable must hold pins and bus answers alike, or a paused core would see glitches.
  property p_freeze;
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    !CORE_CE_I |=> $stable(PE_OUT_O) && $stable(PE_OE_O) && $stable(PD_OUT_O) &&
                   $stable(S_AXI_BVALID_O) && $stable(S_AXI_RVALID_O);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while disabled");

endmodule // pdepf_top

// ===== verif/pdepf_pin_model.sv
// Far-side pin model: resolves the port D and port E pin levels seen by the device.
`timescale 1ns/1ps

module pdepf_pin_model (
  input  wire logic [15:0] pe_out_i,
  input  wire logic [15:0] pe_oe_i,
  input  wire logic [15:0] pe_far_i,
  output logic      [15:0] pe_pin_o,
  input  wire logic [7:0]  pd_out_i,
  input  wire logic [7:0]  pd_oe_i,
  input  wire logic [7:0]  pd_far_i,
  output logic      [7:0]  pd_pin_o
);

  // ****************************************************************
  // Wire resolution
  // ****************************************************************
  // A driven pin shows the device level; a released pin shows the far side's level.
  // The far side always drives, so a released pin never settles to a chosen-by-tool value.
  assign pe_pin_o = (pe_out_i & pe_oe_i) | (pe_far_i & ~pe_oe_i);
  assign pd_pin_o = (pd_out_i & pd_oe_i) | (pd_far_i & ~pd_oe_i);

endmodule // pdepf_pin_model

// ===== verif/pdepf_top_test.sv
// Self-checking testbench for the port D/E pin function block.
`timescale 1ns/1ps

`define CHK(got, exp) begin \
  checks_done++; \
  if ((got) !== (exp)) begin \
    n_mismatch++; \
    $display("Error at %0t: got %h expected %h", $time, got, exp); \
  end \
end

module pdepf_top_test;

  // ****************************************************************
  // Stimulus signals and pin model
  // ****************************************************************
  logic        clk, rst, awvalid, wvalid, bready, arvalid, rready, dbus_oe, tmr_a, tmr_oe;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [7:0]  pd_out, pd_oe, pd_pin, dbus_out, dbus_in, pd_far;
  logic [15:0] pe_out, pe_oe, pe_pin, pe_far;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [3:0]  strb;
  logic        ce;
  int          n_mismatch, checks_done;
  logic [11:0] regs [5] = '{pdepf_pkg::PORTD_FS1_ADDR, pdepf_pkg::PORTD_FS2_ADDR,
                            pdepf_pkg::PE_DIR_ADDR, pdepf_pkg::PE_FS1_ADDR,
                            pdepf_pkg::PE_FS2_ADDR};
  int          pins [10] = '{1, 2, 3, 4, 5, 6, 7, 13, 14, 15};

  // Enable and strobes are driven so that freezing and byte lanes are both exercised.
  pdepf_top u_dut (.CORE_CLK_I(clk), .SYS_RST_I(rst), .CORE_CE_I(ce),
    .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
    .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(strb), .S_AXI_WVALID_I(wvalid),
    .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
    .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
    .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
    .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready), .PD_IN_I(pd_pin), .PD_OUT_O(pd_out),
    .PD_OE_O(pd_oe), .DBUS_OUT_I(dbus_out), .DBUS_OE_I(dbus_oe), .DBUS_IN_O(dbus_in),
    .PE_IN_I(pe_pin), .PE_OUT_O(pe_out), .PE_OE_O(pe_oe), .TMR_CMP_A_I(tmr_a),
    .TMR_OE_I(tmr_oe));

  pdepf_pin_model u_pins (.pe_out_i(pe_out), .pe_oe_i(pe_oe), .pe_far_i(pe_far),
    .pe_pin_o(pe_pin), .pd_out_i(pd_out), .pd_oe_i(pd_oe), .pd_far_i(pd_far),
    .pd_pin_o(pd_pin));

  // ****************************************************************
  // Bus and helper tasks
  // ****************************************************************
  // Closing report, shared by the main sequence and every bus timeout.
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic tmo(input logic done);
    if (done !== 1'b1) begin
      n_mismatch++;
      results();
    end
  endtask

  // Address and data go out together; each is released at the edge that takes it.
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 50);
    bready <= 1'b0;
    tmo(bvalid);
    `CHK(bresp, er)
  endtask

  task automatic rd(input logic [11:0] a, input logic [1:0] er, output logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 50);
    rready <= 1'b0;
    d = rdata;
    tmo(rvalid);
    `CHK(rresp, er)
  endtask

  // Pins lag their register by one clock; three edges leave margin for the pin loop.
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_regs();
    logic [31:0] d;
    foreach (regs[i]) begin
      rd(regs[i], pdepf_pkg::RESP_OKAY, d);
      `CHK(d, 32'h0)
      wr(regs[i], 32'hffffa5c3, pdepf_pkg::RESP_OKAY);
      rd(regs[i], pdepf_pkg::RESP_OKAY, d);
      `CHK(d, 32'h0000a5c3)
      wr(regs[i], 32'h0, pdepf_pkg::RESP_OKAY);
    end
    wr(12'h004, 32'h1, pdepf_pkg::RESP_SLVERR);
    rd(12'h004, pdepf_pkg::RESP_SLVERR, d);
    `CHK(d, 32'h0)
  endtask

  task automatic t_portd();
    dbus_out <= 8'h5a; pd_far <= 8'hc3; dbus_oe <= 1'b0;
    wr(pdepf_pkg::PORTD_FS1_ADDR, 32'h0f, pdepf_pkg::RESP_OKAY);
    settle();
    `CHK({pd_out, pd_oe, dbus_in}, {8'h0a, 8'h00, 8'h03})
    @(posedge clk);
    dbus_oe <= 1'b1;
    wr(pdepf_pkg::PORTD_FS1_ADDR, 32'hff, pdepf_pkg::RESP_OKAY);
    settle();
    `CHK({pd_out, pd_oe}, {8'h5a, 8'hff})
  endtask

  task automatic t_porte();
    logic [31:0] d;
    pe_far <= 16'h1234;
    wr(pdepf_pkg::PE_DIR_ADDR, 32'he0fe, pdepf_pkg::RESP_OKAY);
    wr(pdepf_pkg::PE_DATA_ADDR, 32'he0fe, pdepf_pkg::RESP_OKAY);
    settle();
    `CHK({pe_out, pe_oe}, {16'he0fe, 16'he0fe})
    rd(pdepf_pkg::PE_DATA_ADDR, pdepf_pkg::RESP_OKAY, d);
    `CHK(d, 32'hf2fe)
    pe_far <= 16'hedcb;
    wr(pdepf_pkg::PE_DATA_ADDR, 32'h0002, pdepf_pkg::RESP_OKAY);
    settle();
    `CHK(pe_out, 16'h0002)
    rd(pdepf_pkg::PE_DATA_ADDR, pdepf_pkg::RESP_OKAY, d);
    `CHK(d, 32'h0d03)
  endtask

  task automatic t_timer();
    tmr_a <= 1'b1; tmr_oe <= 1'b1;
    wr(pdepf_pkg::PE_FS2_ADDR, 32'h0001, pdepf_pkg::RESP_OKAY);
    settle();
    `CHK({pe_out[1:0], pe_oe[1:0]}, {2'b11, 2'b11})
    @(posedge clk);
    tmr_a <= 1'b0;
    settle();
    `CHK(pe_out[0], 1'b0)
    wr(pdepf_pkg::PE_FS2_ADDR, 32'h0002, pdepf_pkg::RESP_OKAY);
    settle();
    `CHK({pe_out[0], pe_oe[0]}, 2'b00)
  endtask

  // Code 3 on one field must release that pin and no other.
  task automatic t_fields();
    logic [11:0] a;
    logic [31:0] v;
    wr(pdepf_pkg::PE_DATA_ADDR, 32'he0fe, pdepf_pkg::RESP_OKAY);
    foreach (pins[i]) begin
      a = pins[i] < 8 ? pdepf_pkg::PE_FS2_ADDR : pdepf_pkg::PE_FS1_ADDR;
      v = pins[i] < 8 ? 32'h3 << (2 * pins[i]) : 32'h3 << (2 * pins[i] - 16);
      wr(a, v, pdepf_pkg::RESP_OKAY);
      settle();
      `CHK({pe_out, pe_oe}, {2{16'he0fe & ~(16'h1 << pins[i])}})
      wr(a, 32'h0, pdepf_pkg::RESP_OKAY);
    end
    wr(pdepf_pkg::PE_FS1_ADDR, 32'h03ff, pdepf_pkg::RESP_OKAY);
    settle();
    `CHK({pe_out, pe_oe}, {16'he0fe, 16'he0fe})
  endtask

  // Only the strobed byte may change, and a low enable must hold the pins.
  task automatic t_lanes_ce();
    logic [31:0] d;
    @(posedge clk);
    strb <= 4'h1;
    wr(pdepf_pkg::PE_DIR_ADDR, 32'h00001201, pdepf_pkg::RESP_OKAY);
    strb <= 4'hf;
    rd(pdepf_pkg::PE_DIR_ADDR, pdepf_pkg::RESP_OKAY, d);
    `CHK(d, 32'h0000e001)
    @(posedge clk);
    ce <= 1'b0;
    dbus_out <= 8'ha5;
    settle();
    `CHK(pd_out, 8'h5a)
    @(posedge clk);
    ce <= 1'b1;
    settle();
    `CHK(pd_out, 8'ha5)
  endtask

  // ****************************************************************
  // Clock, reset and main sequence
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    rst = 1'b1; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
    rready = 1'b0; awaddr = '0; araddr = '0; wdata = '0; dbus_out = '0; dbus_oe = 1'b0;
    tmr_a = 1'b0; tmr_oe = 1'b0; pd_far = 8'h96; pe_far = 16'h6996;
    n_mismatch = 0; checks_done = 0;
    ce = 1'b1;
    strb = 4'hf;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_portd();
    t_porte();
    t_timer();
    t_fields();
    t_lanes_ce();
    results();
  end

endmodule // pdepf_top_test
